/* hdl/tpc_channel.sv */
`timescale 1ns/1ps
`include "tpc_defines.svh"

module tpc_channel #(
    parameter int CHANNEL_IDX = 1
) (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    // Register port
    input wire logic [2:0] ADDR_IN,
    input wire logic [15:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [15:0] RDATA_OUT,
    // Prescaled clock ticks, one cycle each
    input wire logic [3:0] PRESCALE_TICK_IN,
    // External pulse input
    input wire logic CAPTURE_PIN_IN,
    // Channel outputs
    output logic CHANNEL_INTERRUPT_OUT,
    output logic CHANNEL_ENABLE_STATUS_OUT
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    tpc_pkg::tpc_word_t mode_reg;
    tpc_pkg::tpc_word_t cnt_reg;
    tpc_pkg::tpc_word_t capt_reg;
    tpc_pkg::tpc_state_e state_reg;
    logic power_reg;
    logic enable_reg;
    logic ovf_reg;
    logic ovf_pend_reg;
    logic irq_reg;
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic pin_prev_reg;
    logic [15:0] rdata_reg;
    logic op_tick;
    logic cnt_tick;
    logic rise;
    logic fall;
    logic wr_mode;
    logic wr_trig;
    logic start_wr;
    logic stop_wr;
    logic start_take;
    logic is_interval;
    logic is_width;
    logic [1:0] cis;
    logic ivl_edge;
    logic w_start_edge;
    logic w_capt_edge;
    logic cnt_wrap;

    // Edge match for a select code; 11 means both edges only in width mode
    function automatic logic edge_match(input logic [1:0] sel, input logic r,
                                        input logic f, input logic width);
        logic m;
        m = 1'b0;
        case (sel)
            `TPC_CIS_FALL: m = f;
            `TPC_CIS_RISE: m = r;
            `TPC_CIS_BOTH: m = r | f;
            default: m = width & (r | f);
        endcase
        return m;
    endfunction

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Mode and trigger writes are refused while the unit is powered off
    assign wr_mode = WR_IN & power_reg & (ADDR_IN == `TPC_ADDR_MODE);
    assign wr_trig = WR_IN & power_reg & (ADDR_IN == `TPC_ADDR_TRIG);
    // Trigger bits act once and are never stored, so they read back as zero
    assign start_wr = wr_trig & WDATA_IN[`TPC_TRIG_START];
    assign stop_wr = wr_trig & WDATA_IN[`TPC_TRIG_STOP];
    // A start the sequencer refuses must not mask a capture or an overflow
    assign start_take = start_wr & (is_interval | (is_width & ~enable_reg));
    assign cis = mode_reg[`TPC_CIS_HI:`TPC_CIS_LO];

    // Mode selection from mode code and trigger select
    assign is_interval = (mode_reg[`TPC_MD_HI:`TPC_MD_LO] == `TPC_MODE_CAPTURE) &&
                         (mode_reg[`TPC_STS_HI:`TPC_STS_LO] == `TPC_STS_INTERVAL);
    assign is_width = (mode_reg[`TPC_MD_HI:`TPC_MD_LO] == `TPC_MODE_ONECOUNT) &&
                      (mode_reg[`TPC_STS_HI:`TPC_STS_LO] == `TPC_STS_WIDTH);

    // Operation clock pick; clocks 2 and 3 exist only on channels 1 and 3
    always_comb begin
        case (mode_reg[`TPC_CKS_HI:`TPC_CKS_LO])
            2'h0: op_tick = PRESCALE_TICK_IN[0];
            2'h2: op_tick = PRESCALE_TICK_IN[1];
            2'h1: op_tick = PRESCALE_TICK_IN[2] & (CHANNEL_IDX == 1 || CHANNEL_IDX == 3);
            default: op_tick = PRESCALE_TICK_IN[3] & (CHANNEL_IDX == 1 || CHANNEL_IDX == 3);
        endcase
    end

    // Only the operation clock is a legal count source; setting the chain bit
    // stops the count because this channel always runs on its own
    assign cnt_tick = op_tick & ~mode_reg[`TPC_CCS_BIT] & power_reg;

    // Edges seen only at operation clock ticks, costing up to one tick of error
    assign rise = op_tick & pin_sync_reg & ~pin_prev_reg;
    assign fall = op_tick & ~pin_sync_reg & pin_prev_reg;
    assign ivl_edge = edge_match(cis, rise, fall, 1'b0);
    // High width starts on rise, low width on fall; capture on the other edge
    assign w_start_edge = cis[0] ? rise : fall;
    assign w_capt_edge = cis[0] ? fall : rise;
    assign cnt_wrap = (cnt_reg == `TPC_CNT_FULL);

    // ------------------------------------------------------------
    // Input pin synchroniser and sampler
    // ------------------------------------------------------------
    // Two flops before any edge logic; pin is not assumed quiet
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= CAPTURE_PIN_IN;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Previous level, updated on the operation clock; it follows the pin while
    // powered off, so power-on never shows a false edge
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pin_prev_reg <= 1'b0;
        end else if (!power_reg) begin
            pin_prev_reg <= pin_sync_reg;
        end else if (op_tick) begin
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // ------------------------------------------------------------
    // Power and mode registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            power_reg <= 1'b0;
        end else if (WR_IN && ADDR_IN == `TPC_ADDR_PWR) begin
            power_reg <= WDATA_IN[0];
        end
    end

    // Software may keep rewriting edge select while running
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            mode_reg <= `TPC_MODE_RESET;
        end else if (!power_reg) begin
            mode_reg <= `TPC_MODE_RESET;
        end else if (wr_mode) begin
            mode_reg <= WDATA_IN;
        end
    end

    // ------------------------------------------------------------
    // Channel sequencer, enable and counter
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_reg <= tpc_pkg::TPC_IDLE;
            enable_reg <= 1'b0;
            cnt_reg <= `TPC_CNT_ZERO;
        end else if (!power_reg) begin
            state_reg <= tpc_pkg::TPC_IDLE;
            enable_reg <= 1'b0;
            cnt_reg <= `TPC_CNT_ZERO;
        end else if (stop_wr) begin
            // Counter keeps its value so software can read where it stopped
            state_reg <= tpc_pkg::TPC_IDLE;
            enable_reg <= 1'b0;
        end else if (start_wr && is_interval) begin
            state_reg <= tpc_pkg::TPC_ARMED;
            enable_reg <= 1'b1;
        end else if (start_wr && is_width && !enable_reg) begin
            state_reg <= tpc_pkg::TPC_WAIT_EDGE;
            enable_reg <= 1'b1;
        end else if (cnt_tick) begin
            // A width start while enabled falls through here untouched
            case (state_reg)
                tpc_pkg::TPC_ARMED: begin
                    cnt_reg <= `TPC_CNT_ZERO;
                    state_reg <= tpc_pkg::TPC_COUNTING;
                end
                tpc_pkg::TPC_WAIT_EDGE: begin
                    if (w_start_edge) begin
                        cnt_reg <= `TPC_CNT_ZERO;
                        state_reg <= tpc_pkg::TPC_COUNTING;
                    end
                end
                tpc_pkg::TPC_COUNTING: begin
                    if (is_interval && ivl_edge) begin
                        cnt_reg <= `TPC_CNT_ZERO;
                    end else if (is_width && w_capt_edge) begin
                        cnt_reg <= cnt_reg + `TPC_CNT_ONE;
                        state_reg <= tpc_pkg::TPC_WAIT_EDGE;
                    end else begin
                        cnt_reg <= cnt_reg + `TPC_CNT_ONE;
                    end
                end
                default: begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Capture data and overflow
    // ------------------------------------------------------------
    // A capture event happens only in counting state on a count tick
    logic capt_evt;
    logic start_evt;
    assign capt_evt = power_reg & ~stop_wr & ~start_take & cnt_tick &
                      (state_reg == tpc_pkg::TPC_COUNTING) &
                      ((is_interval & ivl_edge) | (is_width & w_capt_edge));
    assign start_evt = power_reg & ~stop_wr & ~start_take & cnt_tick &
                       (state_reg == tpc_pkg::TPC_ARMED);

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            capt_reg <= `TPC_CNT_ZERO;
        end else if (!power_reg) begin
            capt_reg <= `TPC_CNT_ZERO;
        end else if (capt_evt) begin
            capt_reg <= cnt_reg;
        end
    end

    // Pending overflow is sticky within one period; more wraps add nothing
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ovf_pend_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end else if (!power_reg) begin
            ovf_pend_reg <= 1'b0;
            ovf_reg <= 1'b0;
        end else if (capt_evt) begin
            ovf_reg <= ovf_pend_reg | cnt_wrap;
            ovf_pend_reg <= 1'b0;
        end else if (start_evt || (cnt_tick && !stop_wr && !start_take &&
                     state_reg == tpc_pkg::TPC_WAIT_EDGE && w_start_edge)) begin
            ovf_pend_reg <= 1'b0;
        end else if (cnt_tick && !stop_wr && !start_take &&
                     state_reg == tpc_pkg::TPC_COUNTING && cnt_wrap) begin
            ovf_pend_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Interrupt and enable outputs
    // ------------------------------------------------------------
    // One-cycle pulse for each capture, or for each interval start when enabled
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= capt_evt | (start_evt & mode_reg[`TPC_MD0_BIT]);
        end
    end

    assign CHANNEL_INTERRUPT_OUT = irq_reg;
    assign CHANNEL_ENABLE_STATUS_OUT = enable_reg;

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Reads only copy state, so polling never disturbs a measurement
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            rdata_reg <= 16'h0000;
        end else if (RD_IN) begin
            case (ADDR_IN)
                `TPC_ADDR_MODE: rdata_reg <= mode_reg;
                `TPC_ADDR_ENST: rdata_reg <= {15'h0000, enable_reg};
                `TPC_ADDR_CNT: rdata_reg <= cnt_reg;
                `TPC_ADDR_CAPT: rdata_reg <= capt_reg;
                `TPC_ADDR_STAT: rdata_reg <= {15'h0000, ovf_reg};
                `TPC_ADDR_PWR: rdata_reg <= {15'h0000, power_reg};
                default: rdata_reg <= 16'h0000;
            endcase
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    assign RDATA_OUT = rdata_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_INTERVAL_START: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (start_wr && is_interval && !stop_wr) |=> enable_reg ##0
        (state_reg == tpc_pkg::TPC_ARMED))
        else $error("interval start did not arm the channel");

    AST_START_IRQ: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        start_evt |=> (irq_reg == $past(mode_reg[`TPC_MD0_BIT])) && (cnt_reg == 16'h0000))
        else $error("start interrupt does not follow select bit");

    AST_IVL_CAPTURE: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (capt_evt && is_interval) |=> (capt_reg == $past(cnt_reg)) &&
        (cnt_reg == 16'h0000) && irq_reg)
        else $error("interval capture wrong");

    AST_OVF_UPDATE: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        capt_evt |=> (ovf_reg == ($past(ovf_pend_reg) || $past(cnt_reg) == 16'hFFFF)))
        else $error("overflow flag not updated at capture");

    AST_STOP_HOLD: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (stop_wr && power_reg) |=> !enable_reg && $stable(cnt_reg) && $stable(ovf_reg))
        else $error("stop did not hold counter and flag");

    AST_POWER_OFF: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        !power_reg |=> !enable_reg && (cnt_reg == 16'h0000) && !ovf_reg &&
        (capt_reg == 16'h0000))
        else $error("power off did not initialise channel");

    AST_WIDTH_START: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (start_wr && is_width && !enable_reg && !stop_wr) |=>
        enable_reg && (state_reg == tpc_pkg::TPC_WAIT_EDGE))
        else $error("width start did not wait for edge");

    AST_WIDTH_CAPTURE: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (capt_evt && is_width) |=> (cnt_reg == capt_reg + 16'h0001) && irq_reg &&
        (state_reg == tpc_pkg::TPC_WAIT_EDGE) ##1
        (cnt_reg == $past(cnt_reg) || $past(w_start_edge) || !$past(power_reg)))
        else $error("width capture did not halt at value plus one");

    AST_WIDTH_RESTART_IGNORED: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        (start_wr && is_width && enable_reg && !stop_wr &&
        (state_reg == tpc_pkg::TPC_COUNTING) && !w_capt_edge) |=>
        (state_reg == tpc_pkg::TPC_COUNTING) &&
        (cnt_reg == $past(cnt_reg) + 16'($past(cnt_tick))))
        else $error("width start accepted while enabled");

    COV_IVL_CAPTURE: cover property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        capt_evt && is_interval);
    COV_WIDTH_CAPTURE: cover property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        capt_evt && is_width);
    COV_OVF_CAPTURE: cover property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        capt_evt && ovf_pend_reg);
    COV_STOP: cover property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
        stop_wr && enable_reg);

endmodule

/* hdl/tpc_defines.svh */
`ifndef TPC_DEFINES_SVH
`define TPC_DEFINES_SVH

// Register indexes on the plain register port
`define TPC_ADDR_MODE 3'h0
`define TPC_ADDR_TRIG 3'h1
`define TPC_ADDR_ENST 3'h2
`define TPC_ADDR_CNT 3'h3
`define TPC_ADDR_CAPT 3'h4
`define TPC_ADDR_STAT 3'h5
`define TPC_ADDR_PWR 3'h6

// Channel mode config field positions
`define TPC_CKS_HI 15
`define TPC_CKS_LO 14
`define TPC_CCS_BIT 12
`define TPC_MS_BIT 11
`define TPC_STS_HI 10
`define TPC_STS_LO 8
`define TPC_CIS_HI 7
`define TPC_CIS_LO 6
`define TPC_MD_HI 3
`define TPC_MD_LO 1
`define TPC_MD0_BIT 0

// Trigger register bits, status bit
`define TPC_TRIG_START 0
`define TPC_TRIG_STOP 1
`define TPC_OVF_BIT 0

// Field codes
`define TPC_MODE_CAPTURE 3'h2
`define TPC_MODE_ONECOUNT 3'h6
`define TPC_STS_INTERVAL 3'h1
`define TPC_STS_WIDTH 3'h2
`define TPC_CIS_FALL 2'h0
`define TPC_CIS_RISE 2'h1
`define TPC_CIS_BOTH 2'h2
`define TPC_CIS_HIGHW 2'h3

// Reset values and counter limits
`define TPC_MODE_RESET 16'h0000
`define TPC_CNT_ZERO 16'h0000
`define TPC_CNT_FULL 16'hFFFF
`define TPC_CNT_ONE 16'h0001

`endif

/* hdl/tpc_pkg.sv */
package tpc_pkg;

    // Channel sequencing states
    typedef enum logic [1:0] {
        TPC_IDLE = 2'b00,
        TPC_WAIT_EDGE = 2'b01,
        TPC_COUNTING = 2'b10,
        TPC_ARMED = 2'b11
    } tpc_state_e;

    typedef logic [15:0] tpc_word_t;

endpackage

/* dv/tpc_pulse_gen.sv */
`timescale 1ns/1ps

// ------------------------------------------------------------
// External pulse source on the capture pin
// ------------------------------------------------------------
module tpc_pulse_gen (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Command from the bench
    input wire logic go_in,
    input wire logic idle_in,
    input wire logic [19:0] act_len_in,
    input wire logic [19:0] idle_len_in,
    input wire logic [3:0] pulses_in,
    // Pin and status
    output logic pin_out,
    output logic busy_out
);
    logic [19:0] left_reg;
    logic [3:0] num_reg;
    logic act_reg;

    // Each pulse leaves idle for act_len cycles, then rests idle_len cycles
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            left_reg <= 20'h00000;
            num_reg <= 4'h0;
            act_reg <= 1'b0;
        end else if (go_in) begin
            act_reg <= 1'b1;
            left_reg <= act_len_in;
            num_reg <= pulses_in;
        end else if (num_reg != 4'h0) begin
            if (left_reg > 20'h00001) begin
                left_reg <= left_reg - 20'h00001;
            end else if (act_reg) begin
                act_reg <= 1'b0;
                left_reg <= idle_len_in;
            end else begin
                num_reg <= num_reg - 4'h1;
                act_reg <= (num_reg > 4'h1);
                left_reg <= act_len_in;
            end
        end
    end

    // Pin moves only just after an edge; the channel must still resynchronise it
    assign pin_out = idle_in ^ act_reg;
    assign busy_out = (num_reg != 4'h0);
endmodule

/* dv/tpc_channel_bench.sv */
`timescale 1ns/1ps
`include "tpc_defines.svh"

// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module tpc_channel_bench;
    logic clk;
    logic rst;
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd_s;
    logic [15:0] rdata;
    logic [3:0] tick;
    logic [3:0] tick_mask;
    logic tick_half;
    logic tog;
    logic pin;
    logic irq;
    logic en_st;
    logic go;
    logic idle_lvl;
    logic [19:0] act_len;
    logic [19:0] idle_len;
    logic [3:0] npulse;
    logic busy;
    logic [15:0] v;
    int err_total;
    int total_checks;
    int irq_cnt;
    logic [1:0] cks_code [4] = '{2'b00, 2'b10, 2'b01, 2'b11};

    tpc_channel #(.CHANNEL_IDX(1)) i_dut (.CLK_SYS_IN(clk), .RST_IN(rst), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd_s), .RDATA_OUT(rdata),
        .PRESCALE_TICK_IN(tick), .CAPTURE_PIN_IN(pin), .CHANNEL_INTERRUPT_OUT(irq),
        .CHANNEL_ENABLE_STATUS_OUT(en_st));

    tpc_pulse_gen i_src (.clk_in(clk), .rst_in(rst), .go_in(go), .idle_in(idle_lvl),
        .act_len_in(act_len), .idle_len_in(idle_len), .pulses_in(npulse),
        .pin_out(pin), .busy_out(busy));

    // ------------------------------------------------------------
    // Clock, prescaled ticks and interrupt counting
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Half-rate ticks on one line only show which prescaled clock is used
    always @(posedge clk) begin
        tog <= ~tog;
        tick <= (tick_half && tog) ? 4'h0 : tick_mask;
        if (irq === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
        end
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic peek(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic rc(input logic [2:0] a, input logic [15:0] exp, input string name);
        peek(a);
        chk(name, exp, v);
    endtask

    // Pulse train from the pin source, bounded wait for it to finish
    task automatic pulses(input int a, input int b, input int n);
        int k;
        @(posedge clk);
        act_len <= a[19:0];
        idle_len <= b[19:0];
        npulse <= n[3:0];
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        #1;
        k = 0;
        while (busy !== 1'b0 && k < 70000) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k == 70000) begin
            err_total++;
            $display("Error pulse source expected idle seen busy");
            tally_and_finish();
        end
        cycles(8);
    endtask

    // Interval capture: two pulses, high 10 and low 14 cycles
    task automatic interval(input logic [1:0] cks, input logic [1:0] cis, input logic md0,
                            input logic [15:0] exp_cap, input int exp_irq);
        int base;
        v = {cks, 3'h0, `TPC_STS_INTERVAL, cis, 2'h0, `TPC_MODE_CAPTURE, md0};
        // Mode is only rewritten while the channel is stopped
        wr_reg(`TPC_ADDR_MODE, v);
        base = irq_cnt;
        wr_reg(`TPC_ADDR_TRIG, 16'h0001);
        cycles(4);
        rc(`TPC_ADDR_ENST, 16'h0001, "enable");
        chk("enable out", 16'h0001, 16'(en_st));
        rc(`TPC_ADDR_TRIG, 16'h0000, "trigger");
        pulses(10, 14, 2);
        rc(`TPC_ADDR_CAPT, exp_cap, "capture");
        rc(`TPC_ADDR_STAT, 16'h0000, "overflow");
        chk("irq count", 16'(exp_irq), 16'(irq_cnt - base));
        wr_reg(`TPC_ADDR_TRIG, 16'h0002);
        rc(`TPC_ADDR_STAT, 16'h0000, "overflow held");
        peek(`TPC_ADDR_CNT);
        cycles(10);
        rc(`TPC_ADDR_CNT, v, "held count");
        rc(`TPC_ADDR_ENST, 16'h0000, "enable");
        chk("enable out", 16'h0000, 16'(en_st));
    endtask

    // Width measurement, with a refused start write in mid-pulse
    task automatic width(input logic [1:0] cis, input logic idl, input int w, input int n,
                         input logic [15:0] exp_cap, input logic [15:0] exp_ovf);
        int base;
        idle_lvl <= idl;
        v = {5'h00, `TPC_STS_WIDTH, cis, 2'h0, `TPC_MODE_ONECOUNT, 1'b0};
        // Output settings are never touched; only the mode word is written
        wr_reg(`TPC_ADDR_MODE, v);
        base = irq_cnt;
        wr_reg(`TPC_ADDR_TRIG, 16'h0001);
        cycles(4);
        rc(`TPC_ADDR_ENST, 16'h0001, "enable");
        fork
            pulses(w, 4, n);
            begin
                cycles(6);
                wr_reg(`TPC_ADDR_TRIG, 16'h0001);
            end
        join
        rc(`TPC_ADDR_CAPT, exp_cap, "width capture");
        rc(`TPC_ADDR_CNT, exp_cap + 16'h0001, "halted count");
        rc(`TPC_ADDR_STAT, exp_ovf, "overflow");
        chk("irq count", 16'(n), 16'(irq_cnt - base));
        wr_reg(`TPC_ADDR_TRIG, 16'h0002);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst, addr, wdata, wr, rd_s, tick_half, tog, go, idle_lvl} = '0;
        {act_len, idle_len, npulse, tick} = '0;
        {err_total, total_checks, irq_cnt} = '0;
        tick_mask = 4'hF;
        rst = 1'b1;
        cycles(4);
        rst <= 1'b0;
        rc(`TPC_ADDR_MODE, `TPC_MODE_RESET, "mode reset");
        rc(`TPC_ADDR_CAPT, 16'h0000, "capture reset");
        rc(3'h7, 16'h0000, "unmapped");
        // Mode and trigger writes are dropped until the unit is powered
        wr_reg(`TPC_ADDR_MODE, 16'h0206);
        rc(`TPC_ADDR_MODE, 16'h0000, "mode while off");
        wr_reg(`TPC_ADDR_PWR, 16'h0001);
        rc(`TPC_ADDR_PWR, 16'h0001, "power");
        $display("Test reset done");
        interval(2'b00, `TPC_CIS_RISE, 1'b1, 16'h0017, 3);
        interval(2'b00, `TPC_CIS_FALL, 1'b0, 16'h0017, 2);
        interval(2'b00, `TPC_CIS_BOTH, 1'b0, 16'h0009, 4);
        $display("Test interval edges done");
        tick_half <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            tick_mask <= 4'h1 << k;
            interval(cks_code[k], `TPC_CIS_RISE, 1'b0, 16'h000B, 2);
        end
        tick_half <= 1'b0;
        tick_mask <= 4'hF;
        // Count source 1 gives no count clock, so the counter must stand still
        v = {4'h1, 1'b0, `TPC_STS_INTERVAL, `TPC_CIS_RISE, 2'h0, `TPC_MODE_CAPTURE, 1'b0};
        wr_reg(`TPC_ADDR_MODE, v);
        wr_reg(`TPC_ADDR_TRIG, 16'h0001);
        peek(`TPC_ADDR_CNT);
        cycles(12);
        rc(`TPC_ADDR_CNT, v, "no count source");
        wr_reg(`TPC_ADDR_TRIG, 16'h0002);
        $display("Test clock select done");
        width(`TPC_CIS_HIGHW, 1'b0, 30, 2, 16'h001D, 16'h0000);
        width(`TPC_CIS_BOTH, 1'b1, 12, 2, 16'h000B, 16'h0000);
        // One wrap of the counter: width is 10000H plus capture plus one
        width(`TPC_CIS_HIGHW, 1'b0, 65540, 1, 16'h0003, 16'h0001);
        width(`TPC_CIS_HIGHW, 1'b0, 20, 1, 16'h0013, 16'h0000);
        $display("Test width done");
        wr_reg(`TPC_ADDR_CAPT, 16'h5A5A);
        rc(`TPC_ADDR_CAPT, 16'h0013, "read-only capture");
        wr_reg(`TPC_ADDR_PWR, 16'h0000);
        rc(`TPC_ADDR_CAPT, 16'h0000, "capture off");
        rc(`TPC_ADDR_CNT, 16'h0000, "count off");
        rc(`TPC_ADDR_MODE, 16'h0000, "mode off");
        $display("Test power off done");
        tally_and_finish();
    end
endmodule
